// ### rtl/field_threshold_regulator_map.svh
/*
 * Register map, field positions, reset values and voltage figures for the
 * field threshold and regulator register slice.
 * Assumes word-aligned 32-bit bus access; byte address = 4 * index.
 */
`ifndef FIELD_THRESHOLD_REGULATOR_MAP_SVH
`define FIELD_THRESHOLD_REGULATOR_MAP_SVH

// Register indices; both spaces share 2B, while 2C is decoded in space A only.
`define IDX_OFF_THRESH 8'h2B
`define IDX_DRV_TIMING 8'h2B
`define IDX_REG_CTRL 8'h2C
`define IDX_SPACE_SEL 8'h30
`define IDX_STATUS 8'h31

// Threshold register fields.
`define THR_PEER_MSB 6
`define THR_PEER_LSB 4
`define THR_COLL_MSB 3
`define THR_COLL_LSB 0
`define THR_RESET 8'h33
`define THR_MASK 8'h7F

// Regulator control fields.
`define REG_SRC_BIT 7
`define REG_CODE_MSB 6
`define REG_CODE_LSB 3
`define REG_MEAS_MSB 2
`define REG_MEAS_LSB 0
`define REG_CTRL_RESET 8'h00

// Regulated voltages in millivolts.
`define MV_5V_BASE 13'h0E10
`define MV_3V3_BASE 13'h076C
`define MV_3V3_MIN 13'h0960
`define MV_STEP 13'h0064
`define MV_DA_5V 13'h0D48
`define CODE_3V3_MIN 4'h5

`endif

// ### rtl/field_threshold_regulator_pkg.sv
/*
 * Types for the field threshold and regulator register slice.
 * Assumes nothing beyond the map header for numbers.
 */
package field_threshold_regulator_pkg;
    // Which of the two register spaces the bus currently sees.
    typedef enum logic {SPACE_A, SPACE_B} reg_space_e;
    // Supply chosen for the measure command.
    typedef enum logic [2:0] {
        MEAS_MAIN, MEAS_ANALOG, MEAS_DIGITAL, MEAS_RF,
        MEAS_AM, MEAS_TX, MEAS_RSVD6, MEAS_RSVD7
    } meas_src_e;
    typedef logic [7:0] reg_byte_t;
    typedef logic [12:0] millivolt_t;
endpackage

// ### rtl/field_threshold_regulator_regs.sv
/*
 * Field detector deactivation thresholds, driver timing readout and
 * regulator voltage control, reached over a classic Wishbone slave.
 * Space A holds the writable threshold and regulator control words; space B
 * shows the live driver timing display at the threshold's index. A small
 * space select word and a status word sit beside them at indices 30h and 31h.
 * Every decoded setting leaves through a flip-flop, one clock after its cause.
 *
 * Assumes a synchronous master on i_mclk, 32-bit words, and the analog
 * side sampling the decoded outputs as static levels. Only the low byte
 * of a word is stored, and only sel[0] lets a write through. The
 * activation register that the collision range must match lives outside
 * and arrives here as a level. Driver timing inputs are taken as
 * synchronous to i_mclk; no resynchronisation is done here.
 */
// Chosen here: the Wishbone register port.
// Operation
// - Space A index 2Bh is read-write threshold register, bit 7 zero.
// - Bits 6..4 hold peer detect code, reset 011, 75 to 800 mVpp.
// - Bits 3..0 collision code, reset 0011, top bit picks fine range.
// - Space B index 2Bh reads driver timing display, read-only.
// - Display upper nibble reports driver transient ratio.
// - Display low bits report timing class; bit 3 reserved.
// - Space A index 2Ch is regulator control, resets to zero.
// - Bit 7 picks adjust-command result or written voltage code.
// - Bits 6..3 voltage code; digital/analog fixed 3.4 V or track RF.
// - Bits 2..0 select measured supply; 110 and 111 reserved.
// - Code maps 3.6-5.1 V in 5 V mode, 2.4-3.4 V in 3.3 V mode.
`timescale 1ns/10ps
`include "field_threshold_regulator_map.svh"

module field_threshold_regulator_regs #(
    parameter int ADR_W = 10
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Wishbone slave.
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Driver timing measurement from the transmitter.
    input wire logic [3:0] i_drv_ratio,
    input wire logic [2:0] i_drv_class,
    // Regulator context.
    input wire logic [3:0] i_adjust_code,
    input wire logic i_mode_5v,
    input wire logic i_act_fine_range,
    // Field detector settings.
    output logic [2:0] o_peer_detect_off_level,
    output logic [3:0] o_collision_avoid_off_level,
    output logic [9:0] o_peer_off_mvpp,
    output logic [9:0] o_coll_off_mvpp,
    output logic o_fine_range_mismatch,
    // Regulator settings.
    output logic [3:0] o_rf_reg_code,
    output field_threshold_regulator_pkg::millivolt_t o_rf_reg_mv,
    output field_threshold_regulator_pkg::millivolt_t o_da_reg_mv,
    output field_threshold_regulator_pkg::meas_src_e o_meas_src,
    output logic o_meas_src_valid
);
    import field_threshold_regulator_pkg::*;

    // Stored register contents and the latched bank choice.
    reg_byte_t thr_r;
    reg_byte_t reg_ctrl_r;
    reg_byte_t drv_disp_r;
    reg_space_e space_r;
    // Bus answer registers; read data is refreshed every cycle.
    logic ack_r;
    logic [31:0] rdat_r;

    // Bus decode: index is the word address.
    wire logic [7:0] idx;
    wire logic req;
    wire logic commit;
    wire logic wr_ok;
    wire logic hit_thr;
    wire logic hit_drv;
    wire logic hit_ctrl;
    wire logic hit_space;
    wire logic hit_status;
    assign idx = i_wb_adr[9:2];
    assign req = i_wb_cyc & i_wb_stb;
    // Writes land on the edge where the master sees ack, never earlier.
    // Ack drops after one cycle but rises again while the request stays high, so a stalled master writes again.
    assign commit = req & ack_r;
    // Byte lane 0 carries the whole register; other lanes alone write nothing.
    assign wr_ok = commit & i_wb_we & i_wb_sel[0];

    // Register hits; the bank choice decides who answers at 2Bh and 2Ch.
    assign hit_thr = (idx == `IDX_OFF_THRESH) & (space_r == SPACE_A);
    assign hit_drv = (idx == `IDX_DRV_TIMING) & (space_r == SPACE_B);
    assign hit_ctrl = (idx == `IDX_REG_CTRL) & (space_r == SPACE_A);
    assign hit_space = idx == `IDX_SPACE_SEL;
    assign hit_status = idx == `IDX_STATUS;

    // Field extraction.
    wire logic [2:0] peer_code;
    wire logic [3:0] coll_code;
    wire logic reg_src_ext;
    wire logic [3:0] ext_code;
    wire logic [2:0] meas_code;
    assign peer_code = thr_r[`THR_PEER_MSB:`THR_PEER_LSB];
    assign coll_code = thr_r[`THR_COLL_MSB:`THR_COLL_LSB];

    // Regulator control fields.
    assign reg_src_ext = reg_ctrl_r[`REG_SRC_BIT];
    assign ext_code = reg_ctrl_r[`REG_CODE_MSB:`REG_CODE_LSB];
    assign meas_code = reg_ctrl_r[`REG_MEAS_MSB:`REG_MEAS_LSB];

    // Status and bank words carry one live bit each; the rest reads zero.
    wire reg_byte_t space_byte;
    wire reg_byte_t status_byte;
    wire logic fine_mismatch;
    assign fine_mismatch = coll_code[3] ^ i_act_fine_range;
    assign space_byte = {7'h00, space_r == SPACE_B};
    assign status_byte = {7'h00, fine_mismatch};

    // Read mux; unmapped words, and space B index 2Ch, read as zero.
    // A priority chain is safe here because at most one hit is ever high.
    wire reg_byte_t rd_byte;
    assign rd_byte = hit_thr ? thr_r :
                     hit_drv ? drv_disp_r :
                     hit_ctrl ? reg_ctrl_r :
                     hit_space ? space_byte :
                     hit_status ? status_byte :
                     8'h00;

    // Threshold lookup, coarse table shared by both codes.
    // Values are in mVpp and ascend with the code.
    function automatic logic [9:0] coarse_mvpp(input logic [2:0] c);
        logic [9:0] v;
        v = 10'h000;
        unique case (c)
            3'h0: v = 10'h04B;
            3'h1: v = 10'h069;
            3'h2: v = 10'h096;
            3'h3: v = 10'h0CD;
            3'h4: v = 10'h122;
            3'h5: v = 10'h190;
            3'h6: v = 10'h230;
            3'h7: v = 10'h320;
        endcase
        return v;
    endfunction

    // Fine collision range for codes with the top bit set.
    // It trades top-end reach for resolution near the weak-field end.
    function automatic logic [9:0] fine_mvpp(input logic [2:0] c);
        logic [9:0] v;
        v = 10'h000;
        unique case (c)
            3'h0: v = 10'h019;
            3'h1: v = 10'h021;
            3'h2: v = 10'h02F;
            3'h3: v = 10'h040;
            3'h4: v = 10'h05A;
            3'h5: v = 10'h07D;
            3'h6: v = 10'h0AF;
            3'h7: v = 10'h0FA;
        endcase
        return v;
    endfunction

    wire logic [9:0] peer_mv;
    wire logic [9:0] coll_mv;
    assign peer_mv = coarse_mvpp(peer_code);
    assign coll_mv = coll_code[3] ? fine_mvpp(coll_code[2:0])
                                  : coarse_mvpp(coll_code[2:0]);

    // Regulator code source and voltage mapping.
    wire logic [3:0] rf_code;
    wire millivolt_t step_mv;
    wire millivolt_t rf_mv_5v;
    wire millivolt_t rf_mv_3v3;
    wire millivolt_t rf_mv;
    wire millivolt_t da_mv;
    assign rf_code = reg_src_ext ? ext_code : i_adjust_code;
    // One code step is 100 mV in either supply mode; the base differs, and 3.3 V mode also clamps low codes.
    assign step_mv = 13'(rf_code * `MV_STEP);
    assign rf_mv_5v = 13'(`MV_5V_BASE + step_mv);
    // Codes below 0101 have no 3.3 V figure; clamp to the lowest one.
    assign rf_mv_3v3 = (rf_code < `CODE_3V3_MIN) ? `MV_3V3_MIN
                                                 : 13'(`MV_3V3_BASE + step_mv);
    assign rf_mv = i_mode_5v ? rf_mv_5v : rf_mv_3v3;
    // Digital and analog rails are pinned in 5 V mode and follow RF otherwise.
    assign da_mv = i_mode_5v ? `MV_DA_5V : rf_mv;

    // Measure source; reserved codes flagged so the command can refuse them.
    // Reserved codes are kept as written so a read returns them unchanged.
    wire logic meas_ok;
    assign meas_ok = meas_code < 3'h6;

    // Bus handshake: ack one cycle after the request, dropped after one.
    // Read data is loaded on the request edge, so it stands during ack.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            rdat_r <= {24'h00_0000, rd_byte};
        end
    end

    // Threshold register; bit 7 is never stored.
    // Masking on write keeps the reserved bit at zero with no read gating.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            thr_r <= `THR_RESET;
        end else if (wr_ok & hit_thr) begin
            thr_r <= i_wb_dat[7:0] & `THR_MASK;
        end
    end

    // Regulator control register; all bits writable.
    // Reserved measure codes are stored; the measure path refuses them.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reg_ctrl_r <= `REG_CTRL_RESET;
        end else if (wr_ok & hit_ctrl) begin
            reg_ctrl_r <= i_wb_dat[7:0];
        end
    end

    // Space select; writes to space B 2Bh fall through as ignored.
    // Only bit 0 is kept; the bank choice applies from the next request.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            space_r <= SPACE_A;
        end else if (wr_ok & hit_space) begin
            space_r <= i_wb_dat[0] ? SPACE_B : SPACE_A;
        end
    end

    // Driver timing display sampled every cycle; bit 3 held at zero.
    // The readout follows the transmitter live, so two reads may differ.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drv_disp_r <= 8'h00;
        end else begin
            drv_disp_r <= {i_drv_ratio, 1'b0, i_drv_class};
        end
    end

    // Raw field copies to the analog side, registered.
    // Registering them keeps decode glitches away from the analog inputs.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_peer_detect_off_level <= 3'h0;
            o_collision_avoid_off_level <= 4'h0;
            o_fine_range_mismatch <= 1'b0;
        end else begin
            o_peer_detect_off_level <= peer_code;
            o_collision_avoid_off_level <= coll_code;
            o_fine_range_mismatch <= fine_mismatch;
        end
    end

    // Threshold voltages in mVpp, registered from the lookup tables.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_peer_off_mvpp <= 10'h000;
            o_coll_off_mvpp <= 10'h000;
        end else begin
            o_peer_off_mvpp <= peer_mv;
            o_coll_off_mvpp <= coll_mv;
        end
    end

    // Regulator code and rails, registered.
    // Switching supply mode moves the rails only at the next clock edge.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rf_reg_code <= 4'h0;
            o_rf_reg_mv <= 13'h0000;
            o_da_reg_mv <= 13'h0000;
        end else begin
            o_rf_reg_code <= rf_code;
            o_rf_reg_mv <= rf_mv;
            o_da_reg_mv <= da_mv;
        end
    end

    // Measure source and its validity flag, registered.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_meas_src <= MEAS_MAIN;
            o_meas_src_valid <= 1'b0;
        end else begin
            o_meas_src <= meas_src_e'(meas_code);
            o_meas_src_valid <= meas_ok;
        end
    end

    // Bus outputs come straight from their flip-flops.
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;
endmodule

// ### tb/field_threshold_regulator_assertions.sv
/* Concurrent checks on the register slice ports.
   Assumes one clock domain and a bind onto the top module. */
`timescale 1ns/10ps
module field_threshold_regulator_assertions
    import field_threshold_regulator_pkg::*;
(
    // Clock, reset and bus.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // Context and decoded settings.
    input wire logic i_mode_5v,
    input wire logic i_act_fine_range,
    input wire logic [3:0] o_collision_avoid_off_level,
    input wire logic [9:0] o_coll_off_mvpp,
    input wire logic o_fine_range_mismatch,
    input wire logic [3:0] o_rf_reg_code,
    input field_threshold_regulator_pkg::millivolt_t o_rf_reg_mv,
    input field_threshold_regulator_pkg::millivolt_t o_da_reg_mv,
    input field_threshold_regulator_pkg::meas_src_e o_meas_src,
    input wire logic o_meas_src_valid
);
    logic up_r;
    // Decoded outputs keep reset values until one edge after release.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) up_r <= 1'b0;
        else up_r <= 1'b1;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_ack_one_cycle: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
    a_ack_pulse: assert property (
        o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    a_dat_upper_zero: assert property (
        o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("upper data set");
    a_meas_valid: assert property (
        up_r |-> o_meas_src_valid == (o_meas_src < MEAS_RSVD6)) else $error("valid wrong");
    a_fine_mismatch: assert property (
        up_r && $stable(o_collision_avoid_off_level) |-> o_fine_range_mismatch ==
        (o_collision_avoid_off_level[3] != $past(i_act_fine_range))) else $error("mismatch");
    a_da_fixed: assert property (
        up_r && $past(i_mode_5v) |-> o_da_reg_mv == 13'h0D48) else $error("da not fixed");
    a_da_track: assert property (
        up_r && !$past(i_mode_5v) && $stable(o_rf_reg_mv) |-> o_da_reg_mv == o_rf_reg_mv)
        else $error("da not tracking");
    a_rf_five_volt: assert property (
        up_r && $past(i_mode_5v) && $stable(o_rf_reg_code) |->
        o_rf_reg_mv == 13'h0E10 + 13'h0064 * o_rf_reg_code) else $error("rf mv wrong");
    a_coll_fine: assert property (
        up_r && o_collision_avoid_off_level == 4'h8 && $stable(o_collision_avoid_off_level)
        |-> o_coll_off_mvpp == 10'h019) else $error("fine range wrong");
endmodule
bind field_threshold_regulator_regs field_threshold_regulator_assertions
    field_threshold_regulator_assertions_i (.i_mclk, .i_rst_n, .i_wb_cyc, .i_wb_stb,
    .o_wb_dat, .o_wb_ack, .i_mode_5v, .i_act_fine_range, .o_collision_avoid_off_level,
    .o_coll_off_mvpp, .o_fine_range_mismatch, .o_rf_reg_code, .o_rf_reg_mv,
    .o_da_reg_mv, .o_meas_src, .o_meas_src_valid);

// ### tb/field_threshold_regulator_regs_tb.sv
/* Self-checking bench for the threshold and regulator slice.
   Assumes a one-cycle Wishbone ack and registered decoded outputs. */
`timescale 1ns/10ps
module field_threshold_regulator_regs_tb;
    import field_threshold_regulator_pkg::*;
    logic i_mclk, i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_mode_5v, i_act_fine_range;
    logic o_wb_ack, o_fine_range_mismatch, o_meas_src_valid;
    logic [9:0] i_wb_adr, o_peer_off_mvpp, o_coll_off_mvpp;
    logic [3:0] i_wb_sel, i_drv_ratio, i_adjust_code, o_collision_avoid_off_level;
    logic [3:0] o_rf_reg_code, c;
    logic [2:0] i_drv_class, o_peer_detect_off_level;
    logic [31:0] i_wb_dat, o_wb_dat;
    millivolt_t o_rf_reg_mv, o_da_reg_mv;
    meas_src_e o_meas_src;
    reg_byte_t rd, v, t;
    int fails, samples_checked, seed, n;
    logic [9:0] pk [8] = '{10'h04B, 10'h069, 10'h096, 10'h0CD, 10'h122, 10'h190,
        10'h230, 10'h320};
    logic [9:0] fk [8] = '{10'h019, 10'h021, 10'h02F, 10'h040, 10'h05A, 10'h07D,
        10'h0AF, 10'h0FA};

    field_threshold_regulator_regs field_threshold_regulator_regs_i (.i_mclk, .i_rst_n,
        .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
        .o_wb_ack, .i_drv_ratio, .i_drv_class, .i_adjust_code, .i_mode_5v,
        .i_act_fine_range, .o_peer_detect_off_level, .o_collision_avoid_off_level,
        .o_peer_off_mvpp, .o_coll_off_mvpp, .o_fine_range_mismatch, .o_rf_reg_code,
        .o_rf_reg_mv, .o_da_reg_mv, .o_meas_src, .o_meas_src_valid);

    // Expected regulated voltage; low codes in 3.3 V mode clamp to the floor.
    function automatic millivolt_t rf_mv(input logic [3:0] k, input logic m5);
        if (m5) return 13'h0E10 + 13'h0064 * k;
        return (k < 4'h5) ? 13'h0960 : 13'h076C + 13'h0064 * k;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic w, input logic [9:0] a, input reg_byte_t d,
        input logic s, output reg_byte_t r);
        @(posedge i_mclk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= {24'h0, d};
        i_wb_sel <= {3'h0, s};
        // Only the watchdog ends a wait that never sees ack.
        do begin
            @(posedge i_mclk);
        end while (o_wb_ack !== 1'b1);
        r = o_wb_dat[7:0];
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic wrap_up;
        $display("checked=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Free-running 100 MHz clock.
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // A hang counts as a mismatch.
    initial begin
        #100000;
        fails++;
        wrap_up;
    end

    // Main sequence: reset values, random and corner writes, both spaces.
    initial begin
        seed = 5155;
        fails = 0;
        samples_checked = 0;
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
        {i_drv_ratio, i_drv_class, i_adjust_code, i_mode_5v, i_act_fine_range} = '0;
        i_rst_n = 1'b0;
        repeat (5) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        wb(1'b0, 10'h0AC, 8'h00, 1'b1, rd);
        chk(rd, 8'h33);
        wb(1'b0, 10'h0B0, 8'h00, 1'b1, rd);
        chk(rd, 8'h00);
        for (n = 0; n < 12; n++) begin
            @(posedge i_mclk);
            v = (n == 0) ? 8'hFF : (n == 1) ? 8'h08 : 8'($random(seed));
            i_act_fine_range <= 1'($random(seed));
            wb(1'b1, 10'h0AC, v, 1'b1, rd);
            wb(1'b0, 10'h0AC, 8'h00, 1'b1, rd);
            chk(rd, v & 8'h7F);
            @(negedge i_mclk);
            chk(o_peer_off_mvpp, pk[v[6:4]]);
            chk(o_coll_off_mvpp, v[3] ? fk[v[2:0]] : pk[v[2:0]]);
            chk(o_fine_range_mismatch, v[3] ^ i_act_fine_range);
            chk(o_peer_detect_off_level, v[6:4]);
            chk(o_collision_avoid_off_level, v[3:0]);
        end
        t = v & 8'h7F;
        wb(1'b1, 10'h0AC, 8'h55, 1'b0, rd);
        wb(1'b0, 10'h0AC, 8'h00, 1'b1, rd);
        chk(rd, t);
        wb(1'b0, 10'h0C4, 8'h00, 1'b1, rd);
        chk(rd, {7'h00, t[3] ^ i_act_fine_range});
        for (n = 0; n < 12; n++) begin
            @(posedge i_mclk);
            v = (n == 0) ? 8'hFF : 8'($random(seed));
            i_adjust_code <= 4'($random(seed));
            i_mode_5v <= 1'($random(seed));
            wb(1'b1, 10'h0B0, v, 1'b1, rd);
            wb(1'b0, 10'h0B0, 8'h00, 1'b1, rd);
            chk(rd, v);
            @(negedge i_mclk);
            c = v[7] ? v[6:3] : i_adjust_code;
            chk(o_rf_reg_code, c);
            chk(o_rf_reg_mv, rf_mv(c, i_mode_5v));
            chk(o_da_reg_mv, i_mode_5v ? 13'h0D48 : rf_mv(c, 1'b0));
            chk({o_meas_src_valid, o_meas_src}, {v[2:0] < 3'h6, v[2:0]});
        end
        wb(1'b1, 10'h0C0, 8'h01, 1'b1, rd);
        wb(1'b0, 10'h0C0, 8'h00, 1'b1, rd);
        chk(rd, 8'h01);
        for (n = 0; n < 4; n++) begin
            i_drv_ratio <= 4'($random(seed));
            i_drv_class <= (n == 0) ? 3'h7 : 3'($random(seed));
            wb(1'b1, 10'h0AC, 8'h00, 1'b1, rd);
            wb(1'b0, 10'h0AC, 8'h00, 1'b1, rd);
            chk(rd, {i_drv_ratio, 1'b0, i_drv_class});
        end
        wb(1'b0, 10'h0B0, 8'h00, 1'b1, rd);
        chk(rd, 8'h00);
        wb(1'b1, 10'h0C0, 8'h00, 1'b1, rd);
        wb(1'b0, 10'h0AC, 8'h00, 1'b1, rd);
        chk(rd, t);
        wb(1'b0, 10'h000, 8'h00, 1'b1, rd);
        chk(rd, 8'h00);
        wrap_up;
    end
endmodule
